// ---- rtl/wrb_bridge.sv ----
`include "wrb_cfg.svh"

module wrb_bridge #(
    parameter logic [6:0] SLAVE_ADDR = `WRB_SLAVE_ADDR,
    parameter int         SLOT_CYC   = `WRB_SLOT_CYC,
    parameter int         LOW_CYC    = `WRB_LOW_CYC,
    parameter int         SAMPLE_CYC = `WRB_SAMPLE_CYC
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Two-wire host bus
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // Single-wire line
    input  wire logic line_in,
    output logic      line_out,
    output logic      line_oe
);
    wrb_eng_if eng_if ();

    wrb_pkg::wrb_bus_st_t st_r, st_nxt;
    logic                 scl_q_r, sda_q_r;
    logic [3:0]           cnt_r, cnt_nxt;
    logic [7:0]           sh_r, sh_nxt;
    logic [7:0]           tx_r, tx_nxt;
    logic                 rw_r, rw_nxt;
    logic                 ptr_data_r, ptr_data_nxt;
    logic                 par_r, par_nxt;
    logic                 mack_r, mack_nxt;
    logic                 oe_r, oe_nxt;
    logic                 go_r, go_nxt;
    logic                 scl_rise, scl_fall, bus_start, bus_stop;
    logic [7:0]           status_byte, tx_byte;

    assign scl_rise  = scl_in & ~scl_q_r;
    assign scl_fall  = ~scl_in & scl_q_r;
    assign bus_start = scl_in & scl_q_r & sda_q_r & ~sda_in;
    assign bus_stop  = scl_in & scl_q_r & ~sda_q_r & sda_in;

    always_comb begin
        status_byte = 8'h00;
        status_byte[`WRB_STAT_BUSY_BIT] = eng_if.busy;
        tx_byte = ptr_data_r ? eng_if.data : status_byte;      // [R2]
    end

    always_comb begin
        st_nxt       = st_r;
        cnt_nxt      = cnt_r;
        sh_nxt       = sh_r;
        tx_nxt       = tx_r;
        rw_nxt       = rw_r;
        ptr_data_nxt = ptr_data_r;
        par_nxt      = par_r;
        mack_nxt     = mack_r;
        oe_nxt       = oe_r;
        go_nxt       = 1'b0;
        if (bus_stop) begin
            st_nxt = wrb_pkg::WRB_IDLE;
            oe_nxt = 1'b0;
        end else if (bus_start) begin
            // Repeated start mid-operation leaves the line engine alone
            st_nxt  = wrb_pkg::WRB_ADDR;                        // [R3]
            cnt_nxt = 4'h0;
            oe_nxt  = 1'b0;
        end else begin
            case (st_r)
                wrb_pkg::WRB_IDLE, wrb_pkg::WRB_WAIT: begin
                    oe_nxt = 1'b0;
                end
                wrb_pkg::WRB_ADDR, wrb_pkg::WRB_CMD, wrb_pkg::WRB_PARAM: begin
                    if (scl_rise && cnt_r != 4'h8) begin
                        sh_nxt  = {sh_r[6:0], sda_in};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == 4'h8) begin
                        st_nxt = wrb_pkg::WRB_WAIT;
                        if (st_r == wrb_pkg::WRB_ADDR) begin
                            if (sh_r[7:1] == SLAVE_ADDR) begin
                                oe_nxt = 1'b1;
                                rw_nxt = sh_r[0];
                                st_nxt = wrb_pkg::WRB_AACK;
                            end
                        end else if (st_r == wrb_pkg::WRB_CMD) begin
                            if (sh_r == `WRB_CMD_SET_PTR) begin
                                oe_nxt  = 1'b1;                 // [R3]
                                par_nxt = 1'b1;
                                st_nxt  = wrb_pkg::WRB_CACK;
                            end else if (sh_r == `WRB_CMD_READ_BYTE && !eng_if.busy) begin
                                oe_nxt       = 1'b1;
                                par_nxt      = 1'b0;
                                go_nxt       = 1'b1;
                                ptr_data_nxt = 1'b0;
                                st_nxt       = wrb_pkg::WRB_CACK;
                            end
                            // Busy or unknown code: left released, host sees NACK [R5]
                        end else begin
                            if (sh_r == `WRB_PTR_READ_DATA) begin
                                oe_nxt       = 1'b1;
                                ptr_data_nxt = 1'b1;            // [R2]
                                st_nxt       = wrb_pkg::WRB_PACK;
                            end else if (sh_r == `WRB_PTR_STATUS) begin
                                oe_nxt       = 1'b1;
                                ptr_data_nxt = 1'b0;
                                st_nxt       = wrb_pkg::WRB_PACK;
                            end
                        end
                    end
                end
                wrb_pkg::WRB_AACK: begin
                    if (scl_fall) begin
                        cnt_nxt = 4'h0;
                        if (rw_r) begin
                            tx_nxt = tx_byte;
                            oe_nxt = ~tx_byte[7];
                            st_nxt = wrb_pkg::WRB_RDATA;
                        end else begin
                            oe_nxt = 1'b0;
                            st_nxt = wrb_pkg::WRB_CMD;
                        end
                    end
                end
                wrb_pkg::WRB_CACK: begin
                    if (scl_fall) begin
                        oe_nxt  = 1'b0;
                        cnt_nxt = 4'h0;
                        st_nxt  = par_r ? wrb_pkg::WRB_PARAM : wrb_pkg::WRB_WAIT;
                    end
                end
                wrb_pkg::WRB_PACK: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b0;
                        st_nxt = wrb_pkg::WRB_WAIT;
                    end
                end
                wrb_pkg::WRB_RDATA: begin
                    if (scl_rise) begin
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_r == 4'h8) begin
                            oe_nxt   = 1'b0;
                            mack_nxt = 1'b0;
                            st_nxt   = wrb_pkg::WRB_MACK;
                        end else begin
                            tx_nxt = {tx_r[6:0], 1'b0};
                            oe_nxt = ~tx_r[6];
                        end
                    end
                end
                wrb_pkg::WRB_MACK: begin
                    if (scl_rise) begin
                        mack_nxt = ~sda_in;
                    end else if (scl_fall) begin
                        cnt_nxt = 4'h0;
                        if (mack_r) begin
                            // Host ACK: fresh copy of the selected register [R4]
                            tx_nxt = tx_byte;
                            oe_nxt = ~tx_byte[7];
                            st_nxt = wrb_pkg::WRB_RDATA;
                        end else begin
                            st_nxt = wrb_pkg::WRB_WAIT;         // [R7]
                        end
                    end
                end
                default: begin
                    st_nxt = wrb_pkg::WRB_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r       <= wrb_pkg::WRB_IDLE;
            scl_q_r    <= 1'b1;
            sda_q_r    <= 1'b1;
            cnt_r      <= 4'h0;
            sh_r       <= 8'h00;
            tx_r       <= 8'h00;
            rw_r       <= 1'b0;
            ptr_data_r <= 1'b0;
            par_r      <= 1'b0;
            mack_r     <= 1'b0;
            oe_r       <= 1'b0;
            go_r       <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            scl_q_r    <= scl_in;
            sda_q_r    <= sda_in;
            cnt_r      <= cnt_nxt;
            sh_r       <= sh_nxt;
            tx_r       <= tx_nxt;
            rw_r       <= rw_nxt;
            ptr_data_r <= ptr_data_nxt;
            par_r      <= par_nxt;
            mack_r     <= mack_nxt;
            oe_r       <= oe_nxt;
            go_r       <= go_nxt;
        end
    end

    assign eng_if.start = go_r;
    assign sda_oe       = oe_r;
    assign sda_out      = 1'b0;

    wrb_line_engine #(
        .SLOT_CYC   (SLOT_CYC),
        .LOW_CYC    (LOW_CYC),
        .SAMPLE_CYC (SAMPLE_CYC)
    ) u_engine (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ctl      (eng_if),
        .line_in  (line_in),
        .line_out (line_out),
        .line_oe  (line_oe)
    );
endmodule // wrb_bridge

// ---- rtl/wrb_cfg.svh ----
`ifndef WRB_CFG_SVH
`define WRB_CFG_SVH
// Behaviour
// R1 - Host waits or polls until the line read finishes before fetching the byte.
// R2 - Set-read-pointer with code E1h makes the next read return the line byte.
// R3 - Set-read-pointer to read data is accepted while the line read runs.
// R4 - Polling reads status repeatedly in one transfer until busy drops to 0.
// R5 - While busy is 1, a new line command code is answered with not-acknowledge.
// R6 - Host stops at once after a refused command and retries later.
// R7 - With pointer on read data, one addressed read fetches the byte, then NACK, stop.
// R8 - Busy drops from 1 to 0 only when the line read has fully finished.
// R9 - Read data holds the last captured byte until another line read completes.

// Bus addressing and codes
`define WRB_SLAVE_ADDR      7'h18
`define WRB_CMD_READ_BYTE   8'hA1
`define WRB_CMD_SET_PTR     8'hB2
`define WRB_PTR_READ_DATA   8'hE1
`define WRB_PTR_STATUS      8'hF0
`define WRB_STAT_BUSY_BIT   0
`define WRB_READ_DATA_RST   8'h00

// Line slot timing
`define WRB_CLK_MHZ         25
`define WRB_SLOT_US         70
`define WRB_LOW_US          6
`define WRB_SAMPLE_US       15
`define WRB_SLOT_CYC        (`WRB_SLOT_US * `WRB_CLK_MHZ)
`define WRB_LOW_CYC         (`WRB_LOW_US * `WRB_CLK_MHZ)
`define WRB_SAMPLE_CYC      (`WRB_SAMPLE_US * `WRB_CLK_MHZ)
`endif

// ---- rtl/wrb_pkg.sv ----
package wrb_pkg;
    typedef enum logic [3:0] {
        WRB_IDLE  = 4'h0,
        WRB_ADDR  = 4'h1,
        WRB_AACK  = 4'h3,
        WRB_CMD   = 4'h2,
        WRB_CACK  = 4'h6,
        WRB_PARAM = 4'h7,
        WRB_PACK  = 4'h5,
        WRB_RDATA = 4'h4,
        WRB_MACK  = 4'hC,
        WRB_WAIT  = 4'hD
    } wrb_bus_st_t;

    typedef enum logic [1:0] {
        WRB_E_IDLE = 2'h0,
        WRB_E_LOW  = 2'h1,
        WRB_E_HIGH = 2'h3
    } wrb_eng_st_t;
endpackage

// ---- rtl/wrb_eng_if.sv ----
interface wrb_eng_if;
    logic       start;
    logic       busy;
    logic [7:0] data;

    modport ctrl (output start, input  busy, input  data);
    modport eng  (input  start, output busy, output data);
endinterface

// ---- rtl/wrb_line_engine.sv ----
`include "wrb_cfg.svh"

module wrb_line_engine #(
    parameter int SLOT_CYC   = `WRB_SLOT_CYC,
    parameter int LOW_CYC    = `WRB_LOW_CYC,
    parameter int SAMPLE_CYC = `WRB_SAMPLE_CYC
) (
    // Clock and reset
    input  wire logic  core_clk,
    input  wire logic  rst_n,
    // Control carrier
    wrb_eng_if.eng     ctl,
    // Single-wire line
    input  wire logic  line_in,
    output logic       line_out,
    output logic       line_oe
);
    wrb_pkg::wrb_eng_st_t st_r, st_nxt;
    logic [11:0]          cyc_r, cyc_nxt;
    logic [2:0]           bit_r, bit_nxt;
    logic [7:0]           sh_r, sh_nxt;
    logic [7:0]           data_r, data_nxt;
    logic                 busy_r, busy_nxt;
    logic                 oe_r, oe_nxt;

    always_comb begin
        st_nxt   = st_r;
        cyc_nxt  = cyc_r;
        bit_nxt  = bit_r;
        sh_nxt   = sh_r;
        data_nxt = data_r;
        busy_nxt = busy_r;
        oe_nxt   = oe_r;
        case (st_r)
            wrb_pkg::WRB_E_IDLE: begin
                if (ctl.start) begin
                    busy_nxt = 1'b1;
                    st_nxt   = wrb_pkg::WRB_E_LOW;
                    cyc_nxt  = 12'h000;
                    bit_nxt  = 3'h0;
                    oe_nxt   = 1'b1;
                end
            end
            wrb_pkg::WRB_E_LOW: begin
                cyc_nxt = cyc_r + 12'h001;
                if (cyc_r == 12'(LOW_CYC - 1)) begin
                    oe_nxt = 1'b0;
                    st_nxt = wrb_pkg::WRB_E_HIGH;
                end
            end
            wrb_pkg::WRB_E_HIGH: begin
                cyc_nxt = cyc_r + 12'h001;
                if (cyc_r == 12'(SAMPLE_CYC - 1)) begin
                    sh_nxt = {line_in, sh_r[7:1]};
                end
                if (cyc_r == 12'(SLOT_CYC - 1)) begin
                    cyc_nxt = 12'h000;
                    if (bit_r == 3'h7) begin
                        data_nxt = sh_r;           // [R9]
                        busy_nxt = 1'b0;           // [R8]
                        st_nxt   = wrb_pkg::WRB_E_IDLE;
                    end else begin
                        bit_nxt = bit_r + 3'h1;
                        oe_nxt  = 1'b1;
                        st_nxt  = wrb_pkg::WRB_E_LOW;
                    end
                end
            end
            default: begin
                st_nxt   = wrb_pkg::WRB_E_IDLE;
                busy_nxt = 1'b0;
                oe_nxt   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r   <= wrb_pkg::WRB_E_IDLE;
            cyc_r  <= 12'h000;
            bit_r  <= 3'h0;
            sh_r   <= 8'h00;
            data_r <= `WRB_READ_DATA_RST;
            busy_r <= 1'b0;
            oe_r   <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            cyc_r  <= cyc_nxt;
            bit_r  <= bit_nxt;
            sh_r   <= sh_nxt;
            data_r <= data_nxt;
            busy_r <= busy_nxt;
            oe_r   <= oe_nxt;
        end
    end

    assign ctl.busy = busy_r;
    assign ctl.data = data_r;
    assign line_oe  = oe_r;
    assign line_out = 1'b0;
endmodule // wrb_line_engine

// ---- dv/wrb_checker.sv ----
module wrb_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Host bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Line
    input wire logic line_in,
    input wire logic line_out,
    input wire logic line_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [3:0] rises_r, rises_nxt;
    logic [7:0] gap_r, gap_nxt;
    // Slot starts per frame; a long quiet gap opens a new frame
    always_comb begin
        gap_nxt   = line_oe ? 8'h00 : ((gap_r == 8'hFF) ? gap_r : gap_r + 8'h01);
        rises_nxt = (gap_r > 8'hC8) ? 4'h0 : rises_r;
        if (line_oe && gap_r != 6'h00) begin
            rises_nxt = rises_nxt + 4'h1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rises_r <= 4'h0;
            gap_r   <= 8'hFF;
        end else begin
            rises_r <= rises_nxt;
            gap_r   <= gap_nxt;
        end
    end
    sequence slot_low_s;
        line_oe[*3] ##1 (!line_oe)[*8];
    endsequence
    pin_const_a: assert property (sda_out == 1'b0 && line_out == 1'b0)
        else $error("open drain data value not zero");
    sda_hold_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data pin moved while clock high");
    ack_setup_a: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("data pin pulled without clock low");
    slot_low_a: assert property ($rose(line_oe) |-> slot_low_s)
        else $error("line slot low time wrong");
    frame_len_a: assert property (rises_r <= 4'h8)
        else $error("line frame longer than eight slots");
    reset_idle_a: assert property ($rose(rst_n) |-> !sda_oe && !line_oe)
        else $error("pins driven after reset");
endmodule // wrb_checker

bind wrb_bridge wrb_checker chk_u (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe));

// ---- dv/wrb_host_model.sv ----
module wrb_host_model (
    // Clock
    input  wire logic core_clk,
    // Host bus
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sda_m;
    // Pull-up wins unless someone pulls low
    assign sda_in = sda_m & ~sda_oe;
    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end
    task q;
        repeat (4) @(posedge core_clk);
    endtask
    task start;
        sda_m <= 1'b1; q;
        scl   <= 1'b1; q;
        sda_m <= 1'b0; q;
        scl   <= 1'b0; q;
    endtask
    task stop;
        sda_m <= 1'b0; q;
        scl   <= 1'b1; q;
        sda_m <= 1'b1; q;
    endtask
    task bit_x(input logic b, output logic r);
        sda_m <= b; q;
        scl   <= 1'b1; q;
        @(negedge core_clk) r = sda_in;
        q;
        scl   <= 1'b0; q;
    endtask
    task wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(b[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask
    task rbyte(output logic [7:0] b, input logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            b[i] = r;
        end
        bit_x(nack, r);
    endtask
endmodule // wrb_host_model

// ---- dv/test_wire_read_byte_host_sequence.sv ----
module test_wire_read_byte_host_sequence;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk, rst_n, scl_in, sda_in, sda_out, sda_oe;
    logic       line_in, line_out, line_oe, ack;
    logic [7:0] lbyte, got;
    int         slot, fail_count, n_tests, cyc;
    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;
    // Line slave: one bit per slot, LSB first, pulled high when released
    always @(posedge line_oe) slot <= slot + 1;
    assign line_in = !line_oe && (slot < 0 || slot > 7 || lbyte[slot[2:0]]);
    wrb_host_model host (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl_in), .sda_in(sda_in));
    wrb_bridge #(.SLOT_CYC(100), .LOW_CYC(3), .SAMPLE_CYC(8)) dut_u (.core_clk(core_clk),
        .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .line_in(line_in), .line_out(line_out), .line_oe(line_oe));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task finish_test;
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task wr(input logic [7:0] b, input logic exp);
        host.wbyte(b, ack);
        chk({7'h00, ack}, {7'h00, exp});
    endtask
    task addr(input logic rd);
        host.start();
        wr({7'h18, rd}, 1'b1);
    endtask
    task set_ptr;
        wr(8'hB2, 1'b1);
        wr(8'hE1, 1'b1);
    endtask
    task fetch;
        addr(1'b1);
        host.rbyte(got, 1'b1);
        host.stop();
        chk(got, lbyte);
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            $display("[FAIL] %0t: run too long", $time);
            finish_test;
        end
    end
    initial begin
        rst_n = 1'b0;
        slot = -1;
        lbyte = 8'h00;
        void'($urandom(1414));
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        for (int t = 0; t < 4; t++) begin
            lbyte <= (t == 0) ? 8'hFF : 8'($urandom);
            slot  <= -1;
            addr(1'b0);
            wr(8'hA1, 1'b1);
            case (t % 3)
                0: begin
                    host.stop();
                    repeat (1000) @(posedge core_clk);
                    addr(1'b0);
                    set_ptr;
                    fetch;
                    fetch;
                end
                1: begin
                    addr(1'b0);
                    set_ptr;
                    host.stop();
                    repeat (1000) @(posedge core_clk);
                    fetch;
                end
                default: begin
                    host.stop();
                    addr(1'b0);
                    wr(8'hA1, 1'b0);
                    host.stop();
                    addr(1'b1);
                    host.rbyte(got, 1'b0);
                    chk(got, 8'h01);
                    for (int k = 0; k < 40 && got[0] === 1'b1; k++) host.rbyte(got, 1'b0);
                    chk(got, 8'h00);
                    chk(8'(slot), 8'h07);
                    host.rbyte(got, 1'b1);
                    addr(1'b0);
                    set_ptr;
                    fetch;
                end
            endcase
            $display("Test %0d done", t);
        end
        finish_test;
    end
endmodule // test_wire_read_byte_host_sequence
